/* include/code_lock_pkg.sv */
package code_lock_pkg;

  // memory geometry
  localparam int CODE_BYTES     = 8192;
  localparam int CODE_AW        = 13;
  localparam int ENC_BYTES      = 64;
  localparam int ENC_AW         = 6;
  localparam int SIG_BYTES      = 4;
  localparam logic [7:0] ERASED = 8'hff;

  // signature locations
  localparam logic [7:0] SIG_LOC0 = 8'h30;
  localparam logic [7:0] SIG_LOC1 = 8'h31;
  localparam logic [7:0] SIG_LOC2 = 8'h60;
  localparam logic [7:0] SIG_LOC3 = 8'h61;

  // apb register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;

  // ctrl field positions and reset value
  localparam int CTRL_ERASE   = 0;
  localparam int CTRL_MASKROM = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // status field positions
  localparam int ST_LOCK1 = 0;
  localparam int ST_LOCK2 = 1;
  localparam int ST_LOCK3 = 2;
  localparam int ST_LEVEL = 4;
  localparam int ST_MODE  = 8;

  typedef enum logic [7:0] {
    MODE_IDLE     = 8'h01,
    MODE_PROG     = 8'h02,
    MODE_VERIFY   = 8'h04,
    MODE_PROG_ENC = 8'h08,
    MODE_SIG      = 8'h10,
    MODE_LOCK1    = 8'h20,
    MODE_LOCK2    = 8'h40,
    MODE_LOCK3    = 8'h80
  } mode_e;

  // pin-level programming interface
  typedef struct packed {
    logic       rst_pin;
    logic       program_store_strobe;
    logic       program_pulse_strobe;
    logic       vpp_high;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
    logic [7:0] p0_in;
  } prog_pins_s;

  typedef struct packed {
    logic [7:0] data;
    logic       oe;
  } prog_out_s;

endpackage : code_lock_pkg

/* hdl/mode_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module mode_decode
(
  // synchronised pins
  input  wire logic [7:0]          p2,
  input  wire logic [7:0]          p3,
  input  wire logic                rst_pin,
  input  wire logic                program_store_strobe,
  input  wire logic                vpp_high,
  // decoded mode
  output code_lock_pkg::mode_e     mode
);
  wire base_ok = rst_pin & ~program_store_strobe;
  wire [5:0] sel = {p2[6], p2[7], p3[3], p3[6], p3[7], vpp_high};

  always_comb
  begin
    mode = code_lock_pkg::MODE_IDLE;
    if (base_ok)
    begin
      casez (sel)
        6'b011111: mode = code_lock_pkg::MODE_PROG;
        6'b0?0110: mode = code_lock_pkg::MODE_VERIFY;
        6'b011011: mode = code_lock_pkg::MODE_PROG_ENC;
        6'b0?0000: mode = code_lock_pkg::MODE_SIG;
        6'b111111: mode = code_lock_pkg::MODE_LOCK1;
        6'b111001: mode = code_lock_pkg::MODE_LOCK2;
        6'b101101: mode = code_lock_pkg::MODE_LOCK3;
        default:   mode = code_lock_pkg::MODE_IDLE;
      endcase
    end
  end
endmodule : mode_decode
`default_nettype wire

/* hdl/code_lock.sv */
`timescale 1ns/1ps
`default_nettype none
module code_lock
#(
  parameter logic [7:0] SIG_BYTE0 = 8'h11,  // arbitrary value
  parameter logic [7:0] SIG_BYTE1 = 8'h22,  // arbitrary value
  parameter logic [7:0] SIG_BYTE2 = 8'h33,  // arbitrary value
  parameter logic [7:0] SIG_BYTE3 = 8'h44   // arbitrary value
)
(
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  input  wire logic                      clk_en,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // programmer pins
  input  wire code_lock_pkg::prog_pins_s pins,
  output code_lock_pkg::prog_out_s       p0_out,
  // core side
  input  wire logic                      core_reset_pulse,
  input  wire logic                      ext_access_pin,
  input  wire logic                      table_read_from_ext,
  input  wire logic [12:0]               core_addr,
  output logic [7:0]                     core_rdata,
  output logic                           table_read_blocked,
  output logic                           external_access_select,
  output logic                           ext_exec_disable
);
  // two-flop synchronisers on pins
  code_lock_pkg::prog_pins_s pins_m_r;
  code_lock_pkg::prog_pins_s pins_s_r;
  logic                      acc_m_r;
  logic                      acc_s_r;

  // storage
  logic [7:0] code_mem [code_lock_pkg::CODE_BYTES];
  logic [7:0] enc_mem  [code_lock_pkg::ENC_BYTES];
  logic       lock_bit_first_r;
  logic       lock_bit_second_r;
  logic       lock_bit_third_r;
  logic [1:0] ctrl_r;
  logic       strobe_d_r;
  logic       acc_latched_r;

  code_lock_pkg::mode_e mode;

  mode_decode u_mode_decode
  (
    .p2                   (pins_s_r.p2),
    .p3                   (pins_s_r.p3),
    .rst_pin              (pins_s_r.rst_pin),
    .program_store_strobe (pins_s_r.program_store_strobe),
    .vpp_high             (pins_s_r.vpp_high),
    .mode                 (mode)
  );

  function automatic logic [7:0] enc_xnor(input logic [7:0] c, input logic [7:0] e);
    enc_xnor = ~(c ^ e);
  endfunction : enc_xnor

  // address assembly
  wire [15:0] prog_addr = {pins_s_r.p3[5:4], pins_s_r.p2[5:0], pins_s_r.p1};
  wire [12:0] code_idx  = prog_addr[12:0];
  wire [5:0]  enc_idx   = prog_addr[5:0];
  wire [7:0]  wdata     = pins_s_r.p0_in;

  // lock decode
  wire masked     = ctrl_r[code_lock_pkg::CTRL_MASKROM];
  wire lvl2       = lock_bit_first_r | lock_bit_second_r | lock_bit_third_r;
  wire lvl3       = lock_bit_second_r | lock_bit_third_r;
  wire lvl4       = lock_bit_third_r & ~masked;
  wire prog_block = lvl2 & ~masked;
  wire [2:0] level = lvl4 ? 3'h4 : lvl3 ? 3'h3 : lvl2 ? 3'h2 : 3'h1;

  wire pulse_rise = pins_s_r.program_pulse_strobe & ~strobe_d_r;
  wire do_write   = pulse_rise & ~prog_block;
  wire erase_cmd  = psel & penable & pwrite & (paddr == code_lock_pkg::REG_CTRL)
                    & pwdata[code_lock_pkg::CTRL_ERASE];

  wire lb3_allowed = ~masked;

  // verify and signature data
  wire [7:0] enc_byte   = enc_mem[enc_idx];
  wire [7:0] verify_val = enc_xnor(code_mem[code_idx], enc_byte);
  wire [7:0] sig_val =
    (prog_addr[7:0] == code_lock_pkg::SIG_LOC0) ? SIG_BYTE0 :
    (prog_addr[7:0] == code_lock_pkg::SIG_LOC1) ? SIG_BYTE1 :
    (prog_addr[7:0] == code_lock_pkg::SIG_LOC2) ? SIG_BYTE2 :
    (prog_addr[7:0] == code_lock_pkg::SIG_LOC3) ? SIG_BYTE3 :
    code_lock_pkg::ERASED;
  wire verify_ok  = (mode == code_lock_pkg::MODE_VERIFY) & ~lvl3;
  wire sig_ok     = (mode == code_lock_pkg::MODE_SIG);
  wire [7:0] p0_nxt = verify_ok ? verify_val : sig_ok ? sig_val : 8'h00;
  wire       oe_nxt = verify_ok | sig_ok;

  // core side read, table read protection
  wire blk_nxt = table_read_from_ext & lvl2;
  wire [7:0] core_nxt = blk_nxt ? 8'h00 : code_mem[core_addr];

  wire [31:0] status_word =
    {16'h0000, 8'(mode), 1'b0, level, 1'b0, lock_bit_third_r,
     lock_bit_second_r, lock_bit_first_r};
  wire [31:0] rd_nxt =
    (paddr == code_lock_pkg::REG_CTRL)   ? {30'h0, ctrl_r} :
    (paddr == code_lock_pkg::REG_STATUS) ? status_word : 32'h0;
  wire unmapped = (paddr != code_lock_pkg::REG_CTRL) & (paddr != code_lock_pkg::REG_STATUS);

  // synchronisers
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      // pulse strobe idles high: no false rising edge after reset
      pins_m_r <= '{program_pulse_strobe: 1'b1, default: '0};
      pins_s_r <= '{program_pulse_strobe: 1'b1, default: '0};
      acc_m_r  <= 1'b0;
      acc_s_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      pins_m_r <= pins;
      pins_s_r <= pins_m_r;
      acc_m_r  <= ext_access_pin;
      acc_s_r  <= acc_m_r;
    end
  end

  // nonvolatile arrays; reset does not touch them, erase does
  always_ff @(posedge sys_clk)
  begin
    if (clk_en)
    begin
      if (erase_cmd)
      begin
        for (int i = 0; i < code_lock_pkg::CODE_BYTES; i++)
          code_mem[i] <= code_lock_pkg::ERASED;
        for (int j = 0; j < code_lock_pkg::ENC_BYTES; j++)
          enc_mem[j] <= code_lock_pkg::ERASED;
      end
      else if (do_write && mode == code_lock_pkg::MODE_PROG)
        code_mem[code_idx] <= wdata;
      else if (do_write && mode == code_lock_pkg::MODE_PROG_ENC)
        enc_mem[enc_idx] <= wdata;
    end
  end

  // lock bits: erased state is unprogrammed (0 here = U)
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      lock_bit_first_r  <= 1'b0;
      lock_bit_second_r <= 1'b0;
      lock_bit_third_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (erase_cmd)
      begin
        lock_bit_first_r  <= 1'b0;
        lock_bit_second_r <= 1'b0;
        lock_bit_third_r  <= 1'b0;
      end
      // a coincident programming pulse wins over erase
      if (pulse_rise)
      begin
        if (mode == code_lock_pkg::MODE_LOCK1)
          lock_bit_first_r <= 1'b1;
        if (mode == code_lock_pkg::MODE_LOCK2)
          lock_bit_second_r <= 1'b1;
        if (mode == code_lock_pkg::MODE_LOCK3 && lb3_allowed)
          lock_bit_third_r <= 1'b1;
      end
    end
  end

  // control, strobes, outputs
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      ctrl_r                 <= code_lock_pkg::CTRL_RESET;
      strobe_d_r             <= 1'b1;
      acc_latched_r          <= 1'b0;
      p0_out                 <= '0;
      core_rdata             <= 8'h00;
      table_read_blocked     <= 1'b0;
      external_access_select <= 1'b0;
      ext_exec_disable       <= 1'b0;
      prdata                 <= 32'h0;
      pready                 <= 1'b0;
      pslverr                <= 1'b0;
    end
    else if (clk_en)
    begin
      strobe_d_r         <= pins_s_r.program_pulse_strobe;
      p0_out.data        <= p0_nxt;
      p0_out.oe          <= oe_nxt;
      core_rdata         <= core_nxt;
      table_read_blocked <= blk_nxt;
      ext_exec_disable   <= lvl4;
      if (core_reset_pulse)
        acc_latched_r <= acc_s_r;
      external_access_select <= lvl2 ? acc_latched_r : acc_s_r;
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & unmapped;
      if (psel && !penable && !pwrite)
        prdata <= rd_nxt;
      if (psel && penable && pwrite && paddr == code_lock_pkg::REG_CTRL)
        ctrl_r <= {pwdata[code_lock_pkg::CTRL_MASKROM], 1'b0};
    end
  end
endmodule : code_lock
`default_nettype wire

/* verification/prog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module prog_model
(
  // clock
  input  wire logic                     clk,
  // pins toward the device
  output var code_lock_pkg::prog_pins_s pins
);
  initial pins = '{rst_pin: 1'b0, program_store_strobe: 1'b1, program_pulse_strobe: 1'b1,
                   default: '0};

  // c holds p2.6, p2.7, p3.3, p3.6, p3.7, vpp
  task automatic op(input logic [5:0] c, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    pins.rst_pin <= 1'b1;
    pins.program_store_strobe <= 1'b0;
    pins.vpp_high <= c[0];
    pins.p1 <= a[7:0];
    pins.p2 <= {c[4], c[5], a[13:8]};
    pins.p3 <= {c[1], c[2], a[15:14], c[3], 3'h0};
    // released data lines flip so a stale byte never looks valid
    pins.p0_in <= c[0] ? d : ~pins.p0_in;
    repeat (4) @(posedge clk);
    if (c[0])
    begin
      pins.program_pulse_strobe <= 1'b0;
      repeat (2) @(posedge clk);
      pins.program_pulse_strobe <= 1'b1;
      repeat (5) @(posedge clk);
      pins.vpp_high <= 1'b0;
      @(posedge clk);
    end
  endtask : op
endmodule : prog_model
`default_nettype wire

/* verification/code_lock_props.sv */
`timescale 1ns/1ps
`default_nettype none
module code_lock_props
#(
  parameter logic [7:0] SIG_BYTE0 = 8'h11
)
(
  // clock and reset
  input wire logic                      sys_clk,
  input wire logic                      resetn,
  // apb
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic [7:0]                paddr,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  // pins and core side
  input wire code_lock_pkg::prog_pins_s pins,
  input wire code_lock_pkg::prog_out_s  p0_out,
  input wire logic                      table_read_blocked,
  input wire logic [7:0]                core_rdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic        setup_w = psel && !penable;
  wire logic        map_w   = paddr == 8'h00 || paddr == 8'h04;
  wire logic [15:0] addr_w  = {pins.p3[5:4], pins.p2[5:0], pins.p1};

  ready_setup_a: assert property (setup_w |=> pready)
    else $error("no ready after setup");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_cause_a: assert property (pready |-> psel && penable)
    else $error("ready without access");
  unmapped_err_a: assert property (setup_w |=> pslverr == !$past(map_w))
    else $error("wrong error response");
  level_code_a: assert property (setup_w && paddr == 8'h04 |=> $onehot(prdata[15:8]) &&
    prdata[6:4] == (prdata[2] ? 3'h4 : prdata[1] ? 3'h3 : prdata[0] ? 3'h2 : 3'h1))
    else $error("level does not match lock bits");
  read_block_a: assert property (table_read_blocked |-> core_rdata == 8'h00)
    else $error("blocked read leaks data");
  data_dir_a: assert property (p0_out.oe |-> $past(pins.rst_pin, 3) &&
    !$past(pins.vpp_high, 3) && !$past(pins.p3[3], 3))
    else $error("data driven outside read modes");
  sig_value_a: assert property (p0_out.oe && !$past(pins.p3[6], 3) &&
    $past(addr_w, 3) == 16'h0030 |-> p0_out.data == SIG_BYTE0)
    else $error("wrong signature byte");
  cover property (pslverr);
  cover property (p0_out.oe && !$past(pins.p3[6], 3));
  cover property (table_read_blocked);
endmodule : code_lock_props
bind code_lock code_lock_props #(.SIG_BYTE0(SIG_BYTE0)) i_code_lock_props (.sys_clk, .resetn,
  .psel, .penable, .paddr, .prdata, .pready, .pslverr, .pins, .p0_out, .table_read_blocked,
  .core_rdata);
`default_nettype wire

/* verification/code_lock_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module code_lock_bench;
  localparam logic [5:0] PROG = 6'h1f, VER = 6'h16, ENC = 6'h1b, SIG = 6'h10;
  localparam logic [5:0] LOCK1 = 6'h3f, LOCK2 = 6'h39, LOCK3 = 6'h2d;
  logic        sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        core_reset_pulse = 1'b0, ext_access_pin = 1'b0, table_read_from_ext = 1'b0;
  logic        clk_en = 1'b1, err;
  logic        pready, pslverr, table_read_blocked, external_access_select, ext_exec_disable;
  logic [7:0]  paddr = 8'h00, core_rdata;
  logic [12:0] core_addr = 13'h0000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [7:0]  sig_loc [4] = '{8'h30, 8'h31, 8'h60, 8'h61};
  logic [7:0]  sig_val [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  int          fails = 0, checks = 0;
  code_lock_pkg::prog_pins_s pins;
  code_lock_pkg::prog_out_s  p0_out;

  always #12.5 sys_clk = ~sys_clk;
  code_lock i_code_lock (.sys_clk, .resetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pins, .p0_out, .core_reset_pulse, .ext_access_pin,
    .table_read_from_ext, .core_addr, .core_rdata, .table_read_blocked,
    .external_access_select, .ext_exec_disable);
  prog_model i_prog_model (.clk(sys_clk), .pins);

  task automatic summarize;
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    // ends once pready is seen high; only the watchdog ends it if pready never comes
    while (pready !== 1'b1)
      @(posedge sys_clk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic st(input logic [31:0] e);
    apb(1'b0, 8'h04, 32'h0);
    chk(r & 32'h7f, e);
  endtask : st

  task automatic op(input logic [5:0] c, input logic [15:0] a, input logic [7:0] d);
    i_prog_model.op(c, a, d);
  endtask : op

  task automatic rd(input logic [5:0] c, input logic [15:0] a, input logic [8:0] e);
    op(c, a, 8'h00);
    @(negedge sys_clk);
    chk({23'h0, p0_out.oe, p0_out.oe ? p0_out.data : 8'h00}, {23'h0, e});
    @(posedge sys_clk);
  endtask : rd

  task automatic core(input logic [9:0] e);
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({22'h0, ext_exec_disable, table_read_blocked, core_rdata}, {22'h0, e});
    @(posedge sys_clk);
  endtask : core

  initial
  begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, 8'h04, 32'h0);
    chk(r & 32'hffff, 32'h0110);
    apb(1'b0, 8'h08, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    chk({31'h0, err}, 32'h0);
    rd(VER, 16'h0045, 9'h1ff);
    op(PROG, 16'h0045, 8'h5a);
    op(PROG, 16'h1fff, 8'h3c);
    op(PROG, 16'h0100, 8'h9e);
    rd(VER, 16'h0045, 9'h15a);
    rd(VER, 16'h1fff, 9'h13c);
    rd(VER, 16'h0100, 9'h19e);
    op(ENC, 16'h0005, 8'h0f);
    rd(VER, 16'h0045, 9'h1aa);
    rd(VER, 16'h1005, 9'h10f);
    // clock enable low: port 0 must hold the last verify byte
    clk_en <= 1'b0;
    rd(VER, 16'h0045, 9'h10f);
    clk_en <= 1'b1;
    op(PROG, 16'h0030, 8'h00);
    for (int i = 0; i < 4; i++)
      rd(SIG, {8'h00, sig_loc[i]}, {1'b1, sig_val[i]});
    table_read_from_ext <= 1'b1;
    ext_access_pin <= 1'b1;
    core_addr <= 13'h0045;
    core(10'h05a);
    op(LOCK1, 16'h0000, 8'h00);
    st(32'h21);
    core_reset_pulse <= 1'b1;
    @(posedge sys_clk);
    core_reset_pulse <= 1'b0;
    ext_access_pin <= 1'b0;
    core(10'h100);
    chk({31'h0, external_access_select}, 32'h1);
    op(PROG, 16'h0045, 8'h00);
    rd(VER, 16'h0045, 9'h1aa);
    op(LOCK2, 16'h0000, 8'h00);
    st(32'h33);
    rd(VER, 16'h0045, 9'h000);
    core(10'h100);
    op(LOCK3, 16'h0000, 8'h00);
    st(32'h47);
    core(10'h300);
    apb(1'b1, 8'h00, 32'h1);
    st(32'h10);
    rd(VER, 16'h0045, 9'h1ff);
    core(10'h0ff);
    apb(1'b1, 8'h00, 32'h2);
    op(LOCK1, 16'h0000, 8'h00);
    op(PROG, 16'h0045, 8'h5a);
    rd(VER, 16'h0045, 9'h15a);
    op(LOCK3, 16'h0000, 8'h00);
    core(10'h100);
    summarize();
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    summarize();
  end
endmodule : code_lock_bench
`default_nettype wire
